//--- src/ref_clock_select_and_clock_outputs.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Select low: 32 kHz oscillator clocks RTC and generator, external ignored.
// - Select high: external reference feeds generator; oscillator only RTC.
// - Source field picks which generator clock reaches debug pin.
// - Disable bit set puts debug clock pin in high impedance.
// - Debug pin enabled after reset until boot sets disable bit.
// - External reference: boot bypasses PLL, assumes 12 MHz of the 11.2896/12/12.288 MHz choices.
// - Boot sets SPI 500 kHz, two-wire 400 kHz, serial 57600 baud.
// - RTC oscillator off: RTC window 1900h-197Fh not reachable.
// - RTC output pin enable bit; after reset pin is high impedance.
// - Wake pin input wakes idle core; defaults to input.
// - Wake pin optional open-drain active-low output on RTC alarm.
module ref_clock_select_and_clock_outputs (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [11:0]                      paddr,
    input  wire logic [31:0]                      pwdata,
    output logic [31:0]                           prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             ref_select_pin,
    input  wire logic                             external_ref_clock_input,
    input  wire logic                             osc_32k,
    input  wire logic [clk_pins_pkg::NUM_SRC-1:0] gen_clks,
    output logic                                  gen_ref_clk,
    output logic                                  rtc_clk,
    output logic                                  debug_clock_output_pin,
    output logic                                  debug_clock_output_oe,
    input  wire logic                             rtc_clk_tap,
    output logic                                  rtc_clock_output_pin,
    output logic                                  rtc_clock_output_oe,
    input  wire logic                             wake_pin_in,
    output logic                                  wake_pin_out,
    output logic                                  wake_pin_oe,
    input  wire logic                             rtc_alarm,
    output logic                                  core_wake,
    input  wire logic                             rtc_access,
    input  wire logic [15:0]                      rtc_io_addr,
    output logic                                  rtc_access_ok,
    output clk_pins_pkg::boot_clk_t               boot_clk
);
    import clk_pins_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic sel_s;
    logic wake_s;

    pin_sync u_sel_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ref_select_pin),
        .pin_s   (sel_s)
    );

    pin_sync u_wake_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (wake_pin_in),
        .pin_s   (wake_s)
    );

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [SRC_W-1:0] src_q;
    logic [SRC_W-1:0] src_d;
    logic             debug_clock_disable_bit_q;
    logic             debug_clock_disable_bit_d;
    logic             rtc_out_en_q;
    logic             rtc_out_en_d;
    logic             wake_out_q;
    logic             wake_out_d;
    logic             rtc_osc_q;
    logic             rtc_osc_d;
    logic             ref_latch_q;
    logic             ref_latch_d;
    logic [1:0]       latched_q;
    logic [1:0]       latched_d;
    logic             wake_prev_q;
    logic             wake_prev_d;
    logic             core_wake_q;
    logic             core_wake_d;
    logic             alarm_q;
    logic             alarm_d;
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;
    logic             wr;
    logic             rd;
    logic             hit;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always_comb
    begin
        unique case (paddr)
            ADDR_SRC_SEL, ADDR_CPU_ST3, ADDR_RTC_PMGT, ADDR_WAKE_CTL,
            ADDR_STATUS, ADDR_BOOT_CLK, ADDR_RTC_WIN: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_comb
    begin
        src_d        = src_q;
        debug_clock_disable_bit_d     = debug_clock_disable_bit_q;
        rtc_out_en_d = rtc_out_en_q;
        wake_out_d   = wake_out_q;
        rtc_osc_d    = rtc_osc_q;
        ref_latch_d  = ref_latch_q;
        latched_d    = latched_q;
        // Wait out both sync stages, then keep the static strap
        if (latched_q != 2'h3)
        begin
            latched_d   = latched_q + 2'h1;
            ref_latch_d = sel_s;
        end
        if (wr)
        begin
            unique case (paddr)
                ADDR_SRC_SEL:  src_d = pwdata[SRC_W-1:0];
                ADDR_CPU_ST3:  debug_clock_disable_bit_d = pwdata[DEBUG_CLOCK_DISABLE_BIT_BIT];
                ADDR_RTC_PMGT:
                    rtc_out_en_d = pwdata[RTC_OUT_EN_BIT];
                ADDR_WAKE_CTL:
                begin
                    wake_out_d = pwdata[WAKE_OUT_BIT];
                    rtc_osc_d  = pwdata[RTC_OSC_EN_BIT];
                end
                default: ;
            endcase
        end
    end

    // Wake event: sticky until read of status; set wins over clear
    always_comb
    begin
        wake_prev_d = wake_s;
        alarm_d     = rtc_alarm;
        core_wake_d = core_wake_q;
        if (rd && paddr == ADDR_STATUS)
            core_wake_d = 1'b0;
        if (!wake_out_q && wake_prev_q && !wake_s)
            core_wake_d = 1'b1;
    end

    always_comb
    begin
        prdata_d = 32'h0;
        if (rd)
        begin
            unique case (paddr)
                ADDR_SRC_SEL:  prdata_d[SRC_W-1:0] = src_q;
                ADDR_CPU_ST3:  prdata_d[DEBUG_CLOCK_DISABLE_BIT_BIT] = debug_clock_disable_bit_q;
                ADDR_RTC_PMGT: prdata_d[RTC_OUT_EN_BIT] = rtc_out_en_q;
                ADDR_WAKE_CTL:
                begin
                    prdata_d[WAKE_OUT_BIT]   = wake_out_q;
                    prdata_d[RTC_OSC_EN_BIT] = rtc_osc_q;
                end
                ADDR_STATUS:
                    prdata_d[3:0] = {alarm_q, core_wake_q, wake_s,
                                     ref_latch_q};
                ADDR_BOOT_CLK:
                    prdata_d = {boot_clk.spi_div, boot_clk.i2c_div};
                ADDR_RTC_WIN:
                    prdata_d[15:0] = boot_clk.uart_div;
                default: ;
            endcase
        end
        else
            prdata_d = prdata_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_q        <= SRC_RESET;
            debug_clock_disable_bit_q     <= DEBUG_CLOCK_DISABLE_BIT_RESET;
            rtc_out_en_q <= RTC_OUT_RESET;
            wake_out_q   <= WAKE_OUT_RESET;
            rtc_osc_q    <= RTC_OSC_RESET;
            ref_latch_q  <= 1'b0;
            latched_q    <= 2'h0;
            // Same level as the sync reset, so no false edge
            wake_prev_q  <= 1'b0;
            core_wake_q  <= 1'b0;
            alarm_q      <= 1'b0;
            prdata_q     <= 32'h0;
        end
        else
        begin
            src_q        <= src_d;
            debug_clock_disable_bit_q     <= debug_clock_disable_bit_d;
            rtc_out_en_q <= rtc_out_en_d;
            wake_out_q   <= wake_out_d;
            rtc_osc_q    <= rtc_osc_d;
            ref_latch_q  <= ref_latch_d;
            latched_q    <= latched_d;
            wake_prev_q  <= wake_prev_d;
            core_wake_q  <= core_wake_d;
            alarm_q      <= alarm_d;
            prdata_q     <= prdata_d;
        end
    end

    // ------------------------------------------------------------------
    // APB answer: no wait states
    // ------------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_q;

    // ------------------------------------------------------------------
    // Clock routing and pins
    // ------------------------------------------------------------------
    logic dbg_clk;

    clk_src_mux u_mux (
        .clk_main (pclk),
        .clk_rtc  (osc_32k),
        .gen_clks (gen_clks),
        .src_sel  (src_q),
        .ref_sel  (ref_select_pin),
        .ext_ref  (external_ref_clock_input),
        .osc_32k  (osc_32k),
        .dbg_clk  (dbg_clk),
        .gen_ref  (gen_ref_clk)
    );

    // RTC always runs from the oscillator whatever the select
    assign rtc_clk = osc_32k;

    // Clock paths are combinational; registering would halve them
    assign debug_clock_output_pin = dbg_clk;
    assign debug_clock_output_oe  = !debug_clock_disable_bit_q;
    assign rtc_clock_output_pin   = rtc_clk_tap;
    assign rtc_clock_output_oe    = rtc_out_en_q;

    // Open drain: only ever pulls low
    assign wake_pin_out = 1'b0;
    assign wake_pin_oe  = wake_out_q && alarm_q;
    assign core_wake    = core_wake_q;

    assign rtc_access_ok = rtc_access && rtc_osc_q &&
                           rtc_io_addr >= RTC_WIN_LO &&
                           rtc_io_addr <= RTC_WIN_HI;

    // Boot figures from the assumed reference when external is used
    always_comb
    begin
        boot_clk.pll_bypass = ref_latch_q;
        boot_clk.spi_div    = SPI_DIV;
        boot_clk.i2c_div    = I2C_DIV;
        boot_clk.uart_div   = UART_DIV;
    end
endmodule

//--- include/clk_pins_pkg.sv
package clk_pins_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, APB)
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_SRC_SEL   = 12'h000;
    localparam logic [11:0] ADDR_CPU_ST3   = 12'h004;
    localparam logic [11:0] ADDR_RTC_PMGT  = 12'h008;
    localparam logic [11:0] ADDR_WAKE_CTL  = 12'h00c;
    localparam logic [11:0] ADDR_STATUS    = 12'h010;
    localparam logic [11:0] ADDR_BOOT_CLK  = 12'h014;
    localparam logic [11:0] ADDR_RTC_WIN   = 12'h018;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          SRC_W          = 3;
    localparam int          NUM_SRC        = 8;
    localparam logic [2:0]  SRC_RESET      = 3'h0;
    localparam int          DEBUG_CLOCK_DISABLE_BIT_BIT     = 0;
    localparam logic        DEBUG_CLOCK_DISABLE_BIT_RESET   = 1'b0;
    localparam int          RTC_OUT_EN_BIT = 0;
    localparam logic        RTC_OUT_RESET  = 1'b0;
    localparam int          WAKE_OUT_BIT   = 0;
    localparam int          RTC_OSC_EN_BIT = 1;
    localparam logic        WAKE_OUT_RESET = 1'b0;
    localparam logic        RTC_OSC_RESET  = 1'b1;

    // RTC register window, I/O word addresses
    localparam logic [15:0] RTC_WIN_LO     = 16'h1900;
    localparam logic [15:0] RTC_WIN_HI     = 16'h197f;

    // ------------------------------------------------------------------
    // Boot clock figures
    // ------------------------------------------------------------------
    localparam int BOOT_SPI_HZ      = 500_000;
    localparam int BOOT_I2C_HZ      = 400_000;
    localparam int BOOT_UART_BAUD   = 57_600;
    localparam int REF_HZ_0         = 11_289_600;
    localparam int REF_HZ_1         = 12_000_000;
    localparam int REF_HZ_2         = 12_288_000;
    localparam int REF_ASSUMED_HZ   = REF_HZ_1;
    localparam logic [15:0] SPI_DIV  = 16'(REF_ASSUMED_HZ / BOOT_SPI_HZ);
    localparam logic [15:0] I2C_DIV  = 16'(REF_ASSUMED_HZ / BOOT_I2C_HZ);
    localparam logic [15:0] UART_DIV =
        16'(REF_ASSUMED_HZ / (16 * BOOT_UART_BAUD));

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [15:0] spi_div;
        logic [15:0] i2c_div;
        logic [15:0] uart_div;
        logic        pll_bypass;
    } boot_clk_t;

endpackage

//--- src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      pin_s
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb
    begin
        meta_d = pin;
        sync_d = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_s = sync_q;
endmodule

//--- src/clk_src_mux.sv
`timescale 1ns/1ps
module clk_src_mux (
    input  wire logic                               clk_main,
    input  wire logic                               clk_rtc,
    input  wire logic [clk_pins_pkg::NUM_SRC-1:0]   gen_clks,
    input  wire logic [clk_pins_pkg::SRC_W-1:0]     src_sel,
    input  wire logic                               ref_sel,
    input  wire logic                               ext_ref,
    input  wire logic                               osc_32k,
    output logic                                    dbg_clk,
    output logic                                    gen_ref
);
    import clk_pins_pkg::*;

    // Debug source picked from the generator taps
    always_comb
    begin
        dbg_clk = gen_clks[src_sel];
    end

    // Reference to clock generator; oscillator alone feeds RTC upstream
    always_comb
    begin
        if (ref_sel)
            gen_ref = ext_ref;
        else
            gen_ref = osc_32k;
    end

    logic unused_ok;
    assign unused_ok = clk_main ^ clk_rtc;
endmodule

//--- test/board_model.sv
`timescale 1ns/1ps
module board_model (
    input  wire logic strap,
    input  wire logic pull_low,
    input  wire logic wake_pin_out,
    input  wire logic wake_pin_oe,
    output logic      ref_select_pin,
    output logic      wake_line
);
    // ----------------------------
    // Board strap and wake line
    // ----------------------------
    // Strap only moves while the device sits in reset
    assign ref_select_pin = strap;
    // Pulled up: whoever pulls low wins, released means high
    assign wake_line = ((wake_pin_oe && !wake_pin_out) || pull_low)
                       ? 1'h0 : 1'h1;
endmodule

//--- test/clk_pins_props.sv
`timescale 1ns/1ps
module clk_pins_props
    import clk_pins_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        ref_select_pin,
    input wire logic        external_ref_clock_input,
    input wire logic        osc_32k,
    input wire logic [7:0]  gen_clks,
    input wire logic        gen_ref_clk,
    input wire logic        rtc_clk,
    input wire logic        debug_clock_output_pin,
    input wire logic        debug_clock_output_oe,
    input wire logic        rtc_clock_output_oe,
    input wire logic        wake_pin_in,
    input wire logic        wake_pin_oe,
    input wire logic        rtc_alarm,
    input wire logic        core_wake,
    input wire logic        rtc_access,
    input wire logic [15:0] rtc_io_addr,
    input wire logic        rtc_access_ok
);
    // ----------------------------
    // Shadow of writable fields
    // ----------------------------
    logic       wr;
    logic [2:0] src_q, src_d;
    logic       off_q, off_d, pm_q, pm_d;
    logic       osc_q, osc_d, wk_q, wk_d;

    assign wr = psel && penable && pwrite;

    always_comb
    begin
        src_d = (wr && paddr == ADDR_SRC_SEL) ? pwdata[2:0] : src_q;
        off_d = (wr && paddr == ADDR_CPU_ST3) ? pwdata[0] : off_q;
        pm_d  = (wr && paddr == ADDR_RTC_PMGT) ? pwdata[0] : pm_q;
        osc_d = (wr && paddr == ADDR_WAKE_CTL) ? pwdata[1] : osc_q;
        wk_d  = (wr && paddr == ADDR_WAKE_CTL) ? pwdata[0] : wk_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_q <= SRC_RESET;
            off_q <= DEBUG_CLOCK_DISABLE_BIT_RESET;
            pm_q  <= RTC_OUT_RESET;
            osc_q <= RTC_OSC_RESET;
            wk_q  <= WAKE_OUT_RESET;
        end
        else
        begin
            src_q <= src_d;
            off_q <= off_d;
            pm_q  <= pm_d;
            osc_q <= osc_d;
            wk_q  <= wk_d;
        end
    end

    // ----------------------------
    // Properties
    // ----------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_GEN_REF:
        assert property (gen_ref_clk ==
            (ref_select_pin ? external_ref_clock_input : osc_32k))
        else $error("generator reference wrong");
    AST_RTC_CLK:
        assert property (rtc_clk == osc_32k)
        else $error("rtc clock not from oscillator");
    AST_DBG_SRC:
        assert property (debug_clock_output_pin == gen_clks[src_q])
        else $error("debug pin source wrong");
    AST_DBG_OE:
        assert property (debug_clock_output_oe == !off_q)
        else $error("debug pin enable wrong");
    AST_RTC_OE:
        assert property (rtc_clock_output_oe == pm_q)
        else $error("rtc pin enable wrong");
    AST_WIN:
        assert property (rtc_access_ok == (rtc_access && osc_q &&
            rtc_io_addr >= RTC_WIN_LO && rtc_io_addr <= RTC_WIN_HI))
        else $error("rtc access outside window");
    AST_WAKE_OE:
        assert property (wake_pin_oe == (wk_q && $past(rtc_alarm)))
        else $error("wake driven without alarm");
    AST_WAKE_IN:
        assert property ($fell(wake_pin_in) && !wake_pin_oe
            |-> ##[2:3] core_wake)
        else $error("wake input ignored");
endmodule

bind ref_clock_select_and_clock_outputs clk_pins_props props_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .ref_select_pin, .external_ref_clock_input, .osc_32k, .gen_clks,
    .gen_ref_clk, .rtc_clk, .debug_clock_output_pin,
    .debug_clock_output_oe, .rtc_clock_output_oe, .wake_pin_in,
    .wake_pin_oe, .rtc_alarm, .core_wake, .rtc_access, .rtc_io_addr,
    .rtc_access_ok
);

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import clk_pins_pkg::*;

    typedef struct packed {
        logic [2:0] src;
        logic [7:0] gen;
        logic       ext;
        logic       osc;
        logic       dbg;
    } row_t;

    logic        pclk = 1'h0, presetn = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, ref_select_pin, wake_line;
    logic        strap = 1'h0, pull_low = 1'h0, rtc_clk_tap = 1'h0;
    logic        external_ref_clock_input = 1'h0, osc_32k = 1'h0;
    logic        rtc_alarm = 1'h0, rtc_access = 1'h0;
    logic [7:0]  gen_clks = 8'h00;
    logic [15:0] rtc_io_addr = 16'h0000;
    logic        gen_ref_clk, rtc_clk, core_wake, rtc_access_ok;
    logic        debug_clock_output_pin, debug_clock_output_oe;
    logic        rtc_clock_output_pin, rtc_clock_output_oe;
    logic        wake_pin_out, wake_pin_oe;
    boot_clk_t   boot_clk;
    int          err_count = 0;
    int          compares = 0;
    int          n;
    logic [15:0] win [4] = '{16'h18ff, 16'h1900, 16'h197f, 16'h1980};
    // Only the selected tap differs from its neighbours
    row_t        rows [8] = '{
        '{3'h0, 8'h01, 1'h1, 1'h0, 1'h1}, '{3'h1, 8'hfd, 1'h0, 1'h1, 1'h0},
        '{3'h2, 8'h04, 1'h1, 1'h1, 1'h1}, '{3'h3, 8'hf7, 1'h1, 1'h0, 1'h0},
        '{3'h4, 8'h10, 1'h0, 1'h0, 1'h1}, '{3'h5, 8'hdf, 1'h1, 1'h1, 1'h0},
        '{3'h6, 8'h40, 1'h0, 1'h1, 1'h1}, '{3'h7, 8'h7f, 1'h0, 1'h0, 1'h0}};

    ref_clock_select_and_clock_outputs dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ref_select_pin,
        .external_ref_clock_input, .osc_32k, .gen_clks, .gen_ref_clk,
        .rtc_clk, .debug_clock_output_pin, .debug_clock_output_oe,
        .rtc_clk_tap, .rtc_clock_output_pin, .rtc_clock_output_oe,
        .wake_pin_in(wake_line), .wake_pin_out, .wake_pin_oe, .rtc_alarm,
        .core_wake, .rtc_access, .rtc_io_addr, .rtc_access_ok, .boot_clk
    );
    board_model brd_u (
        .strap, .pull_low, .wake_pin_out, .wake_pin_oe, .ref_select_pin,
        .wake_line
    );

    always #10 pclk = ~pclk;

    // ----------------------------
    // Shared tasks
    // ----------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered at a rising edge; idle edge at the end avoids double drive
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        for (k = 0; k < 50 && pready !== 1'h1; k++)
            @(posedge pclk);
        if (k == 50)
            err_count++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wrap_up;
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------
    // Main sequence
    // ----------------------------
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk(debug_clock_output_oe, 1'h1);
        chk(rtc_clock_output_oe, 1'h0);
        chk(wake_pin_oe, 1'h0);
        apb(1'h0, ADDR_SRC_SEL, 32'h0);
        chk(rd, 32'h0);
        chk(core_wake, 1'h0);
        foreach (rows[i])
        begin
            apb(1'h1, ADDR_SRC_SEL, {29'h0, rows[i].src});
            gen_clks <= rows[i].gen;
            external_ref_clock_input <= rows[i].ext;
            osc_32k <= rows[i].osc;
            @(posedge pclk);
            chk(debug_clock_output_pin, rows[i].dbg);
            chk(gen_ref_clk, rows[i].osc);
            chk(rtc_clk, rows[i].osc);
        end
        chk(boot_clk.pll_bypass, 1'h0);
        apb(1'h1, ADDR_CPU_ST3, 32'h1);
        chk(debug_clock_output_oe, 1'h0);
        rtc_clk_tap <= 1'h1;
        apb(1'h1, ADDR_RTC_PMGT, 32'h1);
        chk(rtc_clock_output_oe, 1'h1);
        chk(rtc_clock_output_pin, 1'h1);
        rtc_access <= 1'h1;
        for (n = 0; n < 4; n++)
        begin
            rtc_io_addr <= win[n];
            @(posedge pclk);
            chk(rtc_access_ok, n == 1 || n == 2);
        end
        rtc_io_addr <= 16'h1900;
        apb(1'h1, ADDR_WAKE_CTL, 32'h0);
        chk(rtc_access_ok, 1'h0);
        apb(1'h1, ADDR_WAKE_CTL, 32'h2);
        pull_low <= 1'h1;
        for (n = 0; n < 10 && core_wake !== 1'h1; n++)
            @(posedge pclk);
        chk(n < 10, 1'h1);
        pull_low <= 1'h0;
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk(rd[2], 1'h1);
        chk(core_wake, 1'h0);
        apb(1'h1, ADDR_WAKE_CTL, 32'h3);
        rtc_alarm <= 1'h1;
        repeat (2) @(posedge pclk);
        chk(wake_pin_oe, 1'h1);
        chk(wake_line, 1'h0);
        chk(wake_pin_out, 1'h0);
        rtc_alarm <= 1'h0;
        repeat (2) @(posedge pclk);
        chk(wake_line, 1'h1);
        apb(1'h0, 12'h01c, 32'h0);
        chk(er, 1'h1);
        chk(rd, 32'h0);
        // Second reset with the strap high; moved only while held
        presetn <= 1'h0;
        strap <= 1'h1;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        external_ref_clock_input <= 1'h1;
        osc_32k <= 1'h0;
        repeat (4) @(posedge pclk);
        chk(debug_clock_output_oe, 1'h1);
        chk(rtc_clock_output_oe, 1'h0);
        chk(gen_ref_clk, 1'h1);
        chk(rtc_clk, 1'h0);
        chk(boot_clk.pll_bypass, 1'h1);
        // Dividers for the assumed 12 MHz reference, UART at 16x
        chk(boot_clk.spi_div, 12_000_000 / 500_000);
        chk(boot_clk.i2c_div, 12_000_000 / 400_000);
        chk(boot_clk.uart_div, 12_000_000 / (16 * 57_600));
        wrap_up();
    end
endmodule
